// ### clk_irq_pkg.sv
// Package for the clock output and interrupt control block.
// Assumes a single 25 MHz system clock and an Avalon-MM register slave.
package clk_irq_pkg;

    // Register word indices; byte address is four times the index
    localparam logic [2:0] INDEX_CLOCK_OUTPUT_CONTROL = 3'h3;
    localparam logic [2:0] INDEX_INTERRUPT_STATUS = 3'h4;
    localparam logic [2:0] INDEX_INTERRUPT_ENABLE = 3'h5;
    localparam int ADDR_W = 5;

    // Bus response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLAVE_ERROR = 2'h2;

    localparam logic [7:0] RESET_VALUE = 8'h00;
    localparam logic [7:0] CONTROL_WRITE_MASK = 8'hbf;

    // Clock output control bit positions
    localparam int BIT_SOURCE_SELECT = 7;
    localparam int BIT_TEN_MHZ = 5;
    localparam int BIT_EIGHT_CLK = 4;
    localparam int BIT_EIGHT_FRAME = 3;
    localparam int BIT_FOUR_CLK = 2;
    localparam int BIT_FOUR_FRAME = 1;
    localparam int BIT_TWO_CLK = 0;

    // Interrupt status / enable bit positions
    localparam int BIT_MSG_RX_FIFO_ERROR = 7;
    localparam int BIT_MSG_RX_LEVEL = 6;
    localparam int BIT_MSG_TX = 5;
    localparam int BIT_TONE_MODEM_TX = 4;
    localparam int BIT_ENERGY_B = 3;
    localparam int BIT_ENERGY_A = 2;
    localparam int BIT_CONFERENCE_OVERFLOW = 1;
    localparam int BIT_MISSING_CLOCK = 0;
    localparam int NUM_SOURCES = 8;

    typedef enum logic [1:0] {
        REF_FOUR_MHZ = 2'b00,
        REF_EIGHT_MHZ = 2'b01,
        REF_EIGHT_NO_FRAME = 2'b10,
        REF_SIXTEEN_MHZ = 2'b11
    } clock_ref_type;

    // Timing configuration held outside the block
    typedef struct packed {
        logic synth_enable;
        logic synth_clock_select;
        clock_ref_type clock_reference_select;
    } timing_cfg_type;

    // Pin enables and timing sources
    typedef struct packed {
        logic ten_mhz_clock_out;
        logic eight_mhz_clock_pin;
        logic eight_mhz_frame_out;
        logic four_mhz_clock_pin;
        logic four_mhz_frame_out;
        logic two_mhz_clock_pin;
    } pin_oe_type;

    typedef struct packed {
        logic outgoing_from_synth;
        logic expansion_from_synth;
    } timing_src_type;

endpackage

// ### clk_irq_ctrl.sv
// Clock output gating and interrupt status/enable registers.
// Assumes sources pulse on clk_sys, timing config arrives on clk_sys.
//
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/1ps

// Function
// - Synth enabled and source bit set: outgoing timing from synthesizer.
// - Source bit clear or synth off, reference not four MHz: outgoing timing from input reference.
// - Four MHz reference forces expansion and outgoing timing from synthesizer.
// - Ten MHz output driven only with its enable and synth enabled.
// - Eight MHz clock pin driven only with enable and reference code not 01 (eight MHz).
// - Eight kHz frame driven only with enable and reference code not 01 (eight MHz).
// - Four MHz clock, four MHz frame, two MHz clock follow their enables.
// - Bit 7 receive FIFO error, bit 6 receive length or level reached.
// - Bit 5 flags message transmit FIFO empty, 3/4 empty or done.
// - Bit 4 flags tone modem memory empty or transmission ended.
// - Bits 3 and 2 flag energy detectors B and A.
// - Bit 1 flags conference accumulator overflow.
// - Bit 0 flags missing eight MHz input; monitored only when enabled.
// - Status register is read only and cleared by a read.
// - Enabled status bits drive the active-low interrupt output.
// - Disabled bits other than bit 0 still set and read but do not assert interrupt.
// - All three registers reset to zero; outputs off, interrupts disabled.
// - Synth enable gates the ten MHz output.
// - Reference codes: 00 four, 01 eight, 10 eight no frame, 11 sixteen.
module clk_irq_ctrl
    import clk_irq_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [1:0] avs_response,
    // Timing configuration from the timing control register
    input wire timing_cfg_type timing_cfg,
    // Interrupt source pulses, one per status bit
    input wire logic [NUM_SOURCES-1:0] irq_source,
    // Outputs
    output pin_oe_type pin_oe,
    output timing_src_type timing_src,
    output logic irq_n
);

    logic [7:0] control_ff;
    logic [7:0] status_ff;
    logic [7:0] enable_ff;
    logic [31:0] readdata_ff;
    logic waitrequest_ff;
    logic [1:0] response_ff;
    pin_oe_type pin_oe_ff;
    timing_src_type timing_src_ff;
    logic irq_n_ff;

    logic access_done;
    logic [2:0] reg_index;
    logic word_ok;
    logic mapped;
    logic status_read;
    logic [NUM_SOURCES-1:0] event_in;
    logic [7:0] nxt_readdata;
    logic control_write;
    logic enable_write;
    logic ref_is_four;
    logic ref_is_eight;
    logic nxt_irq_n;
    logic nxt_ten_oe;
    logic nxt_eight_clk_oe;
    logic nxt_eight_frame_oe;
    logic nxt_four_clk_oe;
    logic nxt_four_frame_oe;
    logic nxt_two_clk_oe;
    logic nxt_outgoing_synth;
    logic nxt_expansion_synth;

    // Each access answers one cycle after it is raised
    assign access_done = (avs_read || avs_write) && waitrequest_ff;
    assign reg_index = avs_address[ADDR_W-1:2];
    assign word_ok = (avs_address[1:0] == 2'b00);
    assign mapped = word_ok && (reg_index == INDEX_CLOCK_OUTPUT_CONTROL
        || reg_index == INDEX_INTERRUPT_STATUS || reg_index == INDEX_INTERRUPT_ENABLE);
    assign status_read = access_done && avs_read && word_ok
        && reg_index == INDEX_INTERRUPT_STATUS;
    assign control_write = access_done && avs_write && word_ok
        && reg_index == INDEX_CLOCK_OUTPUT_CONTROL;
    assign enable_write = access_done && avs_write && word_ok
        && reg_index == INDEX_INTERRUPT_ENABLE;
    assign ref_is_four = timing_cfg.clock_reference_select == REF_FOUR_MHZ;
    assign ref_is_eight = timing_cfg.clock_reference_select == REF_EIGHT_MHZ;
    assign nxt_irq_n = ~|(status_ff & enable_ff);

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            waitrequest_ff <= 1'b1;
        end
        else
        begin
            waitrequest_ff <= ~access_done;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            response_ff <= RESP_OKAY;
        end
        else if (access_done)
        begin
            response_ff <= mapped ? RESP_OKAY : RESP_SLAVE_ERROR;
        end
    end

    always_comb
    begin
        nxt_readdata = 8'h00;
        if (word_ok)
        begin
            if (reg_index == INDEX_CLOCK_OUTPUT_CONTROL)
            begin
                nxt_readdata = control_ff & CONTROL_WRITE_MASK;
            end
            else if (reg_index == INDEX_INTERRUPT_STATUS)
            begin
                nxt_readdata = status_ff;
            end
            else if (reg_index == INDEX_INTERRUPT_ENABLE)
            begin
                nxt_readdata = enable_ff;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            readdata_ff <= 32'h0000_0000;
        end
        else if (access_done && avs_read)
        begin
            readdata_ff <= {24'h000000, nxt_readdata};
        end
    end

    // Control register; bit 6 never stored
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            control_ff <= RESET_VALUE;
        end
        else if (control_write)
        begin
            control_ff <= avs_writedata[7:0] & CONTROL_WRITE_MASK;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            enable_ff <= RESET_VALUE;
        end
        else if (enable_write)
        begin
            enable_ff <= avs_writedata[7:0];
        end
    end

    // Status bits: set wins over clear-on-read; missing clock only when monitored
    generate
        for (genvar i = 0; i < NUM_SOURCES; i++)
        begin : g_status
            if (i == BIT_MISSING_CLOCK)
            begin : g_mon
                assign event_in[i] = irq_source[i] && enable_ff[i];
            end
            else
            begin : g_src
                assign event_in[i] = irq_source[i];
            end
            always_ff @(posedge clk_sys)
            begin
                if (rst)
                begin
                    status_ff[i] <= 1'b0;
                end
                else if (event_in[i])
                begin
                    status_ff[i] <= 1'b1;
                end
                else if (status_read)
                begin
                    status_ff[i] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            irq_n_ff <= 1'b1;
        end
        else
        begin
            irq_n_ff <= nxt_irq_n;
        end
    end

    // Ten MHz output needs the synthesizer running
    always_comb
    begin
        if (!control_ff[BIT_TEN_MHZ])
        begin
            nxt_ten_oe = 1'b0;
        end
        else if (!timing_cfg.synth_enable)
        begin
            nxt_ten_oe = 1'b0;
        end
        else
        begin
            nxt_ten_oe = 1'b1;
        end
    end

    always_comb
    begin
        if (!control_ff[BIT_EIGHT_CLK])
        begin
            nxt_eight_clk_oe = 1'b0;
        end
        else if (ref_is_eight)
        begin
            nxt_eight_clk_oe = 1'b0;
        end
        else
        begin
            nxt_eight_clk_oe = 1'b1;
        end
    end

    always_comb
    begin
        if (!control_ff[BIT_EIGHT_FRAME])
        begin
            nxt_eight_frame_oe = 1'b0;
        end
        else if (ref_is_eight)
        begin
            nxt_eight_frame_oe = 1'b0;
        end
        else
        begin
            nxt_eight_frame_oe = 1'b1;
        end
    end

    // Plain enables follow their control bits
    always_comb
    begin
        if (control_ff[BIT_FOUR_CLK])
        begin
            nxt_four_clk_oe = 1'b1;
        end
        else
        begin
            nxt_four_clk_oe = 1'b0;
        end
    end

    always_comb
    begin
        if (control_ff[BIT_FOUR_FRAME])
        begin
            nxt_four_frame_oe = 1'b1;
        end
        else
        begin
            nxt_four_frame_oe = 1'b0;
        end
    end

    always_comb
    begin
        if (control_ff[BIT_TWO_CLK])
        begin
            nxt_two_clk_oe = 1'b1;
        end
        else
        begin
            nxt_two_clk_oe = 1'b0;
        end
    end

    // Timing source: four MHz reference forces the synthesizer
    always_comb
    begin
        if (ref_is_four)
        begin
            nxt_outgoing_synth = 1'b1;
        end
        else if (timing_cfg.synth_enable && control_ff[BIT_SOURCE_SELECT])
        begin
            nxt_outgoing_synth = 1'b1;
        end
        else
        begin
            nxt_outgoing_synth = 1'b0;
        end
    end

    always_comb
    begin
        if (ref_is_four)
        begin
            nxt_expansion_synth = 1'b1;
        end
        else if (timing_cfg.synth_enable && control_ff[BIT_SOURCE_SELECT])
        begin
            nxt_expansion_synth = 1'b1;
        end
        else
        begin
            nxt_expansion_synth = 1'b0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            pin_oe_ff <= '0;
            timing_src_ff <= '0;
        end
        else
        begin
            pin_oe_ff.ten_mhz_clock_out <= nxt_ten_oe;
            pin_oe_ff.eight_mhz_clock_pin <= nxt_eight_clk_oe;
            pin_oe_ff.eight_mhz_frame_out <= nxt_eight_frame_oe;
            pin_oe_ff.four_mhz_clock_pin <= nxt_four_clk_oe;
            pin_oe_ff.four_mhz_frame_out <= nxt_four_frame_oe;
            pin_oe_ff.two_mhz_clock_pin <= nxt_two_clk_oe;
            timing_src_ff.outgoing_from_synth <= nxt_outgoing_synth;
            timing_src_ff.expansion_from_synth <= nxt_expansion_synth;
        end
    end

    assign avs_readdata = readdata_ff;
    assign avs_waitrequest = waitrequest_ff;
    assign avs_response = response_ff;
    assign pin_oe = pin_oe_ff;
    assign timing_src = timing_src_ff;
    assign irq_n = irq_n_ff;

endmodule

// ### clk_irq_chk.sv
// Checker for clock output gating and interrupt registers.
// Assumes it is bound to clk_irq_ctrl and shadows bus writes.
`timescale 1ns/1ps
module clk_irq_chk
    import clk_irq_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Register bus
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [1:0] avs_response,
    // Pins and sources
    input wire timing_cfg_type timing_cfg,
    input wire logic [NUM_SOURCES-1:0] irq_source,
    input wire pin_oe_type pin_oe,
    input wire timing_src_type timing_src,
    input wire logic irq_n
);
    logic [7:0] ctl_ff;
    logic [7:0] en_ff;
    logic [5:0] exp_oe;
    logic exp_src;
    logic done;
    logic mapped;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    assign done = (avs_read || avs_write) && !avs_waitrequest;
    assign mapped = avs_address inside {5'h0c, 5'h10, 5'h14};
    assign exp_oe = {ctl_ff[5] & timing_cfg.synth_enable,
        ctl_ff[4:3] & {2{timing_cfg.clock_reference_select != REF_EIGHT_MHZ}}, ctl_ff[2:0]};
    assign exp_src = (timing_cfg.synth_enable && ctl_ff[7])
        || timing_cfg.clock_reference_select == REF_FOUR_MHZ;
    // Shadow of the writable registers, taken at the edge the design writes
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            ctl_ff <= 8'h00;
            en_ff <= 8'h00;
        end
        else if (avs_write && avs_waitrequest && avs_address == 5'h0c)
            ctl_ff <= avs_writedata[7:0] & 8'hbf;
        else if (avs_write && avs_waitrequest && avs_address == 5'h14)
            en_ff <= avs_writedata[7:0];
    end
    sequence s_taken;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_answer;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    a_wait_one_cycle: assert property (s_taken |=> s_answer)
        else $error("waitrequest not one cycle");
    a_bus_response: assert property (done |-> avs_response == (mapped ? 2'b00 : 2'b10))
        else $error("bad response");
    a_reg_readback: assert property (done && avs_read && avs_address inside {5'h0c, 5'h14}
        |-> avs_readdata == {24'h0, avs_address[4] ? en_ff : ctl_ff})
        else $error("readback mismatch");
    a_ten_mhz_gate: assert property (!$past(rst) |-> pin_oe[5] == $past(exp_oe[5]))
        else $error("ten MHz enable wrong");
    a_eight_mhz_gate: assert property (!$past(rst) |-> pin_oe[4:3] == $past(exp_oe[4:3]))
        else $error("eight MHz enables wrong");
    a_plain_enables: assert property (!$past(rst) |-> pin_oe[2:0] == $past(exp_oe[2:0]))
        else $error("plain enables wrong");
    a_timing_source: assert property (!$past(rst) |-> timing_src == {2{$past(exp_src)}})
        else $error("timing source wrong");
    a_irq_assert: assert property (|(irq_source & en_ff) |-> ##2 !irq_n)
        else $error("irq not asserted");
    a_irq_release: assert property (done && avs_read && avs_address == 5'h10
        && irq_source == 8'h00 && $past(irq_source) == 8'h00 |-> ##2 irq_n)
        else $error("irq not released");
    a_disabled_quiet: assert property ($past(en_ff) == 8'h00 |-> irq_n)
        else $error("irq with no enables");
endmodule

// ### event_model.sv
// Model of the interrupt sources feeding the block.
// Assumes the bench pulses fire for one clock per event.
`timescale 1ns/1ps
module event_model
    import clk_irq_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Event requests and source lines
    input wire logic [NUM_SOURCES-1:0] fire,
    output logic [NUM_SOURCES-1:0] irq_source
);
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            irq_source <= '0;
        else
            irq_source <= fire;
    end
endmodule

// ### tb_clk_irq_ctrl.sv
// Self-checking bench for the clock output and interrupt block.
// Assumes the checker and event model are compiled first.
`timescale 1ns/1ps
module tb_clk_irq_ctrl
    import clk_irq_pkg::*;
;
    logic clk_sys;
    logic rst;
    logic [ADDR_W-1:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [1:0] avs_response;
    timing_cfg_type timing_cfg;
    logic [NUM_SOURCES-1:0] fire;
    logic [NUM_SOURCES-1:0] irq_source;
    pin_oe_type pin_oe;
    timing_src_type timing_src;
    logic irq_n;
    logic [33:0] exp_q[$];
    int err_count = 0;
    int n_compared = 0;
    logic [7:0] v;
    logic [7:0] e;
    clk_irq_ctrl u_clk_irq_ctrl(.clk_sys, .rst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest, .avs_response, .timing_cfg,
        .irq_source, .pin_oe, .timing_src, .irq_n);
    event_model u_event_model(.clk_sys, .rst, .fire, .irq_source);
    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [33:0] seen, input logic [33:0] exp, input string what);
        n_compared++;
        if (seen !== exp)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("Compared %0d, errors %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
        int n;
        n = 0;
        avs_write <= w;
        avs_read <= !w;
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 20);
        if (avs_waitrequest !== 1'b0)
        begin
            err_count++;
            summarize();
        end
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] x, input logic [1:0] resp);
        exp_q.push_back({resp, 24'h0, x});
        bus(1'b0, a, 8'h00);
    endtask
    always @(posedge clk_sys)
        if (avs_read && !avs_waitrequest && exp_q.size() > 0)
            chk({avs_response, avs_readdata}, exp_q.pop_front(), "readdata");
    initial
    begin
        rst = 1'b1;
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = '0;
        timing_cfg = '0;
        fire = '0;
        void'($urandom(32'hda52e0a1));
        repeat (7) @(posedge clk_sys);
        @(negedge clk_sys);
        chk({pin_oe, timing_src, irq_n}, 9'h001, "reset pins");
        @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        rd(5'h0c, 8'h00, 2'b00);
        rd(5'h14, 8'h00, 2'b00);
        for (int i = 0; i < 16; i++)
        begin
            v = 8'($urandom);
            timing_cfg <= timing_cfg_type'(i[3:0]);
            bus(1'b1, 5'h0c, v);
            rd(5'h0c, v & 8'hbf, 2'b00);
            chk(pin_oe, {v[5] & i[3], v[4:3] & {2{i[1:0] != 2'b01}}, v[2:0]}, "pin_oe");
            chk(timing_src, {2{(i[3] & v[7]) | (i[1:0] == 2'b00)}}, "timing_src");
        end
        bus(1'b1, 5'h10, 8'hff);
        rd(5'h10, 8'h00, 2'b00);
        rd(5'h18, 8'h00, 2'b10);
        e = 8'($urandom);
        for (int p = 0; p < 2; p++)
        begin
            bus(1'b1, 5'h14, e);
            for (int i = 0; i < 8; i++)
            begin
                fire <= 8'h01 << i;
                @(posedge clk_sys);
                fire <= 8'h00;
                repeat (4) @(posedge clk_sys);
                chk(irq_n, !e[i], "irq_n");
                v = (i == 0 && !e[0]) ? 8'h00 : 8'h01 << i;
                rd(5'h10, v, 2'b00);
                rd(5'h10, 8'h00, 2'b00);
                chk(irq_n, 1'b1, "irq_n clear");
            end
            e = ~e;
        end
        summarize();
    end
endmodule
bind clk_irq_ctrl clk_irq_chk u_clk_irq_chk(.clk_sys, .rst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .avs_response,
    .timing_cfg, .irq_source, .pin_oe, .timing_src, .irq_n);
